// *** include/amh_pkg.sv ***
/*
 * amh_pkg: register map, field positions, reset values and state codes
 * of the analog multiplexer and hold control block.
 * assumes: 32-bit APB, every register one aligned word.
 */
package amh_pkg;
    // register byte addresses
    localparam logic [7:0] AMH_SEL_OFS    = 8'h00;
    localparam logic [7:0] AMH_CTL_OFS    = 8'h04;
    localparam logic [7:0] AMH_STAT_OFS   = 8'h08;
    localparam logic [7:0] AMH_MASK_OFS   = 8'h0c;
    localparam logic [7:0] AMH_COUNT_OFS  = 8'h10;

    // analog_select_register fields
    localparam int AMH_SEL_CHAN_LSB       = 0;
    localparam int AMH_SEL_CHAN_W         = 4;
    localparam int AMH_SEL_DIVIDED_BIT    = 4;
    localparam int AMH_SEL_DIRECT_BIT     = 5;
    localparam int AMH_SEL_SWAP_BIT       = 7;
    localparam logic [7:0] AMH_SEL_RESET  = 8'h20;

    // control register fields
    localparam int AMH_CTL_OFFSET_BIT     = 0;
    localparam int AMH_CTL_SWSTART_BIT    = 1;
    localparam int AMH_CTL_SRC_LSB        = 2;
    localparam int AMH_CTL_PB4_BIT        = 4;
    localparam logic [7:0] AMH_CTL_RESET  = 8'h00;

    // status and mask fields (same layout)
    localparam int AMH_FLAG_N             = 3;
    localparam int AMH_FLAG_COMP1         = 0;
    localparam int AMH_FLAG_COMP2         = 1;
    localparam int AMH_FLAG_DONE          = 2;
    localparam int AMH_STAT_CMP1_BIT      = 4;
    localparam int AMH_STAT_CMP2_BIT      = 5;
    localparam int AMH_STAT_BUSY_BIT      = 6;
    localparam logic [2:0] AMH_MASK_RESET = 3'h0;

    localparam int AMH_COUNT_W            = 16;

    typedef enum logic [1:0] {
        AMH_SRC_SOFT    = 2'b00,
        AMH_SRC_COMPARE = 2'b01,
        AMH_SRC_OVERFLW = 2'b10,
        AMH_SRC_ANY     = 2'b11
    } amh_src_t;

    typedef enum logic [0:0] {
        AMH_IDLE    = 1'b0,
        AMH_RAMPING = 1'b1
    } amh_state_t;
endpackage

// *** sim/amh_mux_hold_ctrl_chk.sv ***
/* amh_mux_hold_ctrl_chk: port-level assertions for the mux and hold
 * control block.
 * assumes: bound to amh_mux_hold_ctrl, single pclk domain. */
`timescale 1ns/10ps
module amh_mux_hold_ctrl_chk (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       pwrite,
    input wire logic       analog_options,
    input wire logic       cmp1_raw,
    input wire logic [3:0] channel_select_bits,
    input wire logic       cap_isolated,
    input wire logic       src_divided,
    input wire logic       src_direct,
    input wire logic       src_diode,
    input wire logic       cap_offset_on,
    input wire logic       comparator_swap,
    input wire logic       port_b_bit_four,
    input wire logic       port_b_bit_four_oe,
    input wire logic       timer_capture
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sel_onehot_a: assert property (
        $onehot({cap_isolated, src_divided, src_direct, src_diode}))
        else $error("source select not one-hot");
    offset_hold_a: assert property (
        cap_offset_on |-> cap_isolated) else $error("offset outside hold");
    offset_strap_a: assert property (
        (!analog_options)[*3] |-> !cap_offset_on)
        else $error("offset without strap");
    // reset values must show while reset is held, so no disable here
    reset_state_a: assert property (
        disable iff (1'b0) !presetn |-> src_direct && !comparator_swap
        && channel_select_bits == 4'h0) else $error("bad reset state");
    swap_write_a: assert property (
        $changed(comparator_swap) |-> $past(psel && pwrite, 2))
        else $error("swap moved without write");
    chan_write_a: assert property (
        $changed(channel_select_bits) |-> $past(psel && pwrite, 2))
        else $error("channel moved without write");
    pb4_level_a: assert property (
        (port_b_bit_four_oe && $stable(cmp1_raw)
         && $stable(comparator_swap))[*3]
        |-> port_b_bit_four == (cmp1_raw ^ comparator_swap))
        else $error("port pin not external compare");
    capture_pulse_a: assert property (
        timer_capture |=> !timer_capture)
        else $error("capture pulse too long");
endmodule // amh_mux_hold_ctrl_chk

bind amh_mux_hold_ctrl amh_mux_hold_ctrl_chk u_chk (
    .pclk, .presetn, .psel, .pwrite, .analog_options, .cmp1_raw,
    .channel_select_bits, .cap_isolated, .src_divided, .src_direct,
    .src_diode, .cap_offset_on, .comparator_swap, .port_b_bit_four,
    .port_b_bit_four_oe, .timer_capture
);

// *** sim/test_analog_mux_hold_control.sv ***
/* test_analog_mux_hold_control: self-checking bench, random and corner
 * stimulus over APB and the comparator and timer inputs.
 * assumes: package, design and bound checker compiled first. */
`timescale 1ns/10ps
module test_analog_mux_hold_control;
    import amh_pkg::*;
    logic        pclk = 1'h0, presetn = 1'h1, psel = 1'h0;
    logic        penable = 1'h0, pwrite = 1'h0, analog_options = 1'h0;
    logic        cmp1_raw = 1'h0, cmp2_raw = 1'h0;
    logic        timer_compare = 1'h0, timer_overflow = 1'h0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, d;
    logic        pready, pslverr, cap_isolated, src_divided, src_direct;
    logic        src_diode, cap_offset_on, comparator_swap, timer_capture;
    logic        port_b_bit_four, port_b_bit_four_oe, irq, rerr;
    logic [3:0]  channel_select_bits, ch = 4'h0;
    int          err_count = 0, num_checks = 0, cyc = 0, k;

    amh_mux_hold_ctrl u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .analog_options, .cmp1_raw,
        .cmp2_raw, .timer_compare, .timer_overflow, .channel_select_bits,
        .cap_isolated, .src_divided, .src_direct, .src_diode,
        .cap_offset_on, .comparator_swap, .port_b_bit_four,
        .port_b_bit_four_oe, .timer_capture, .irq
    );

    always #12.5 pclk = ~pclk;

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one idle cycle after each transfer keeps drivers single-assigned
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        tick(1);
        penable <= 1'h1;
        do tick(1); while (pready !== 1'h1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        tick(1);
    endtask

    task automatic trig(input logic [1:0] m);
        timer_compare <= m[0];
        timer_overflow <= m[1];
        tick(1);
        timer_compare <= 1'h0;
        timer_overflow <= 1'h0;
        tick(1);
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    task automatic end_of_test;
        if (err_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            end_of_test;
        end
    end

    initial begin
        void'($urandom(32'hdc5b));
        // falling edge at time zero, so state is known at the first edge
        presetn <= 1'h0;
        tick(8);
        presetn <= 1'h1;
        tick(1);
        apb(1'h0, AMH_SEL_OFS, 32'h0);
        chk(rd, 32'h20);
        chk(32'({channel_select_bits, src_direct}), 32'h1);
        // code, strap and offset enable swept; channel random
        for (int c = 0; c < 16; c++) begin
            // hold first on the old channel, only then move the channel
            apb(1'h1, AMH_SEL_OFS, 32'(ch));
            ch = 4'($urandom);
            analog_options <= c[2];
            apb(1'h1, AMH_SEL_OFS, 32'(ch));
            apb(1'h1, AMH_CTL_OFS, 32'(c[3]));
            apb(1'h1, AMH_SEL_OFS, 32'({c[1:0], ch}));
            tick(2);
            chk(32'({cap_isolated, src_divided, src_direct, src_diode}),
                32'(4'h8 >> c[1:0]));
            chk(32'(cap_offset_on),
                32'(c[3:2] == 2'h3 && c[1:0] == 2'h0));
            chk(32'(channel_select_bits), 32'(ch));
        end
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            apb(1'h1, AMH_SEL_OFS, d);
            apb(1'h0, AMH_SEL_OFS, 32'h0);
            chk(rd & 32'hffffffbf, d & 32'hbf);
        end
        apb(1'h1, 8'h14, 32'hffffffff);
        chk(32'(rerr), 32'h1);
        apb(1'h0, 8'h14, 32'h0);
        chk({rd[30:0], rerr}, 32'h1);
        apb(1'h1, AMH_SEL_OFS, 32'h20);
        tick(3);
        apb(1'h1, AMH_STAT_OFS, 32'h7);
        apb(1'h1, AMH_MASK_OFS, 32'h1);
        cmp1_raw <= 1'h1;
        tick(4);
        chk(32'(irq), 32'h1);
        apb(1'h0, AMH_STAT_OFS, 32'h0);
        chk(rd & 32'h13, 32'h11);
        apb(1'h1, AMH_MASK_OFS, 32'h0);
        tick(2);
        chk(32'(irq), 32'h0);
        apb(1'h1, AMH_MASK_OFS, 32'h1);
        tick(2);
        chk(32'(irq), 32'h1);
        apb(1'h1, AMH_STAT_OFS, 32'h1);
        tick(2);
        chk(32'(irq), 32'h0);
        cmp1_raw <= 1'h0;
        tick(3);
        apb(1'h1, AMH_STAT_OFS, 32'h7);
        // swap alone flips both internal levels, flags may latch
        apb(1'h1, AMH_SEL_OFS, 32'ha0);
        tick(3);
        apb(1'h0, AMH_STAT_OFS, 32'h0);
        chk(rd & 32'h33, 32'h33);
        apb(1'h1, AMH_STAT_OFS, 32'h3);
        apb(1'h0, AMH_STAT_OFS, 32'h0);
        chk(rd & 32'h3, 32'h0);
        apb(1'h1, AMH_CTL_OFS, 32'h10);
        for (int i = 0; i < 4; i++) begin
            cmp1_raw <= 1'($urandom);
            tick(4);
            chk(32'({port_b_bit_four_oe, port_b_bit_four}),
                32'({1'h1, ~cmp1_raw}));
        end
        apb(1'h1, AMH_SEL_OFS, 32'h20);
        for (int s = 0; s < 4; s++) begin
            cmp2_raw <= 1'h0;
            apb(1'h1, AMH_CTL_OFS, 32'(s << 2));
            apb(1'h1, AMH_STAT_OFS, 32'h7);
            trig(2'(s == 0 ? 3 : 3 ^ s));
            apb(1'h0, AMH_STAT_OFS, 32'h0);
            chk(rd & 32'h40, 32'h0);
            if (s == 0)
                apb(1'h1, AMH_CTL_OFS, 32'h2);
            else
                trig(2'(s));
            tick(2);
            apb(1'h0, AMH_STAT_OFS, 32'h0);
            chk(rd & 32'h40, 32'h40);
            cmp2_raw <= 1'h1;
            k = 0;
            while (timer_capture !== 1'h1 && k < 20) begin
                tick(1);
                k++;
            end
            chk(32'(timer_capture), 32'h1);
            tick(2);
            apb(1'h0, AMH_STAT_OFS, 32'h0);
            chk(rd & 32'h44, 32'h4);
            // ramp count must have run and must freeze once idle
            apb(1'h0, AMH_COUNT_OFS, 32'h0);
            d = rd;
            tick(3);
            apb(1'h0, AMH_COUNT_OFS, 32'h0);
            chk(rd, d);
            chk(32'(d != 32'h0), 32'h1);
        end
        end_of_test;
    end
endmodule // test_analog_mux_hold_control

// *** verilog/amh_flag_bank.sv ***
/*
 * amh_flag_bank: per-bit rising edge detection into sticky flags that
 * software clears by writing one.
 * assumes: event inputs already synchronous to pclk.
 */
`timescale 1ns/10ps
module amh_flag_bank #(
    parameter int N = 3
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] level_in,
    input  wire logic [N-1:0] clear_in,
    output logic      [N-1:0] flag_out
);
    logic [N-1:0] prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= level_in;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            // a new edge in the clearing cycle keeps the flag set
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_out[i] <= 1'b0;
                end else if (level_in[i] && !prev_reg[i]) begin
                    flag_out[i] <= 1'b1;
                end else if (clear_in[i]) begin
                    flag_out[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule // amh_flag_bank

// *** verilog/amh_mux_hold_ctrl.sv ***
/*
 * amh_mux_hold_ctrl: APB register block steering the comparator 2
 * source switches, sample offset, comparator swap, conversion timing
 * and comparator flags of the analog subsystem.
 * assumes: analog comparator raw outputs and timer pulses arrive
 * synchronous to pclk; mask option is a static strap.
 */
`timescale 1ns/10ps

// Overview of operation
// - both select bits clear: capacitor isolated, drives comparator 2 only
// - divided bit alone: half channel bus feeds capacitor and comparator 2
// - direct bit alone: channel bus undivided feeds capacitor, comparator 2
// - both select bits set: temperature diode feeds capacitor, comparator 2
// - hold case, option and offset enable set: raise capacitor bottom plate
// - reset sets direct bit, clears divided bit
// - reset clears channel bits, bus grounded, capacitor discharged
// - swap bit exchanges comparator inputs and inverts their outputs
// - outputs high only when positive pin exceeds negative pin; flags latch their rising edges
// - reset clears the swap bit
// - swap toggling may itself set a comparator flag
// - conversion starts on timer compare, overflow or software bit
// - conversion end by capture pulse, interrupt, or polled level
// - comparator 1 output can drive port B bit four directly
module amh_mux_hold_ctrl
    import amh_pkg::*;
#(
    parameter int COUNT_W = AMH_COUNT_W
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               analog_options,
    input  wire logic               cmp1_raw,
    input  wire logic               cmp2_raw,
    input  wire logic               timer_compare,
    input  wire logic               timer_overflow,
    output logic [AMH_SEL_CHAN_W-1:0] channel_select_bits,
    output logic                    cap_isolated,
    output logic                    src_divided,
    output logic                    src_direct,
    output logic                    src_diode,
    output logic                    cap_offset_on,
    output logic                    comparator_swap,
    output logic                    port_b_bit_four,
    output logic                    port_b_bit_four_oe,
    output logic                    timer_capture,
    output logic                    irq
);
    logic [7:0]         select_reg;
    logic [7:0]         control_reg;
    logic [2:0]         mask_reg;
    logic [COUNT_W-1:0] count_reg;
    logic               cmp1_reg;
    logic               cmp2_reg;
    logic               swstart_reg;
    amh_state_t         state_reg;
    logic [2:0]         flags;
    logic [2:0]         flag_clear;
    logic               wr_en;
    logic               acc;
    logic               start_evt;
    logic               end_evt;
    logic               cmp2_prev_reg;
    logic [31:0]        rd_next;
    logic               err_next;
    amh_src_t           src_sel;

    assign acc    = psel && penable && !pready;
    // writes land on the edge where the master sees pready high
    assign wr_en  = psel && penable && pready && pwrite;
    assign src_sel = amh_src_t'(control_reg[AMH_CTL_SRC_LSB +: 2]);

    // analog register: reset follows channel bus on ground
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_reg <= AMH_SEL_RESET;
        end else if (wr_en && paddr == AMH_SEL_OFS) begin
            select_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg <= AMH_CTL_RESET;
        end else if (wr_en && paddr == AMH_CTL_OFS) begin
            control_reg <= pwdata[7:0] & ~(8'h01 << AMH_CTL_SWSTART_BIT);
        end
    end

    // start bit is a write pulse, never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            swstart_reg <= 1'b0;
        end else begin
            swstart_reg <= wr_en && paddr == AMH_CTL_OFS
                           && pwdata[AMH_CTL_SWSTART_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= AMH_MASK_RESET;
        end else if (wr_en && paddr == AMH_MASK_OFS) begin
            mask_reg <= pwdata[2:0];
        end
    end

    assign flag_clear = (wr_en && paddr == AMH_STAT_OFS) ? pwdata[2:0]
                                                         : 3'h0;

    // source switch decode, registered so the switch lines never glitch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_isolated  <= 1'b0;
            src_divided   <= 1'b0;
            src_direct    <= 1'b1;
            src_diode     <= 1'b0;
            cap_offset_on <= 1'b0;
            channel_select_bits <= '0;
        end else begin
            unique case ({select_reg[AMH_SEL_DIRECT_BIT],
                          select_reg[AMH_SEL_DIVIDED_BIT]})
                2'b00: begin
                    cap_isolated <= 1'b1;
                    src_divided  <= 1'b0;
                    src_direct   <= 1'b0;
                    src_diode    <= 1'b0;
                end
                2'b01: begin
                    cap_isolated <= 1'b0;
                    src_divided  <= 1'b1;
                    src_direct   <= 1'b0;
                    src_diode    <= 1'b0;
                end
                2'b10: begin
                    cap_isolated <= 1'b0;
                    src_divided  <= 1'b0;
                    src_direct   <= 1'b1;
                    src_diode    <= 1'b0;
                end
                2'b11: begin
                    cap_isolated <= 1'b0;
                    src_divided  <= 1'b0;
                    src_direct   <= 1'b0;
                    src_diode    <= 1'b1;
                end
            endcase
            // offset only while holding, and only if the strap allows it
            cap_offset_on <= !select_reg[AMH_SEL_DIRECT_BIT]
                             && !select_reg[AMH_SEL_DIVIDED_BIT]
                             && analog_options
                             && control_reg[AMH_CTL_OFFSET_BIT];
            channel_select_bits <=
                select_reg[AMH_SEL_CHAN_LSB +: AMH_SEL_CHAN_W];
        end
    end

    // swap drives the analog input exchange; raw outputs are inverted
    // back so the corrected level always means positive pin above
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_swap <= 1'b0;
            cmp1_reg        <= 1'b0;
            cmp2_reg        <= 1'b0;
        end else begin
            comparator_swap <= select_reg[AMH_SEL_SWAP_BIT];
            cmp1_reg <= cmp1_raw ^ comparator_swap;
            cmp2_reg <= cmp2_raw ^ comparator_swap;
        end
    end

    // direct comparator 1 output pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_bit_four    <= 1'b0;
            port_b_bit_four_oe <= 1'b0;
        end else begin
            port_b_bit_four    <= cmp1_reg;
            port_b_bit_four_oe <= control_reg[AMH_CTL_PB4_BIT];
        end
    end

    always_comb begin
        unique case (src_sel)
            AMH_SRC_SOFT:    start_evt = swstart_reg;
            AMH_SRC_COMPARE: start_evt = swstart_reg || timer_compare;
            AMH_SRC_OVERFLW: start_evt = swstart_reg || timer_overflow;
            AMH_SRC_ANY:     start_evt = swstart_reg || timer_compare
                                         || timer_overflow;
        endcase
    end

    assign end_evt = state_reg == AMH_RAMPING && cmp2_reg && !cmp2_prev_reg;

    // ramp timing: count from start until comparator 2 trips
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= AMH_IDLE;
            count_reg     <= '0;
            cmp2_prev_reg <= 1'b0;
            timer_capture <= 1'b0;
        end else begin
            cmp2_prev_reg <= cmp2_reg;
            timer_capture <= end_evt;
            unique case (state_reg)
                AMH_IDLE: begin
                    if (start_evt) begin
                        state_reg <= AMH_RAMPING;
                        count_reg <= '0;
                    end
                end
                AMH_RAMPING: begin
                    if (end_evt) begin
                        state_reg <= AMH_IDLE;
                    end else if (count_reg != '1) begin
                        count_reg <= count_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    // swap toggles pass through the same edge path, so spurious flags
    // from the exchange are kept rather than filtered
    amh_flag_bank #(
        .N (AMH_FLAG_N)
    ) u_flags (
        .pclk     (pclk),
        .presetn  (presetn),
        .level_in ({end_evt, cmp2_reg, cmp1_reg}),
        .clear_in (flag_clear),
        .flag_out (flags)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flags & mask_reg);
        end
    end

    always_comb begin
        rd_next  = 32'h0000_0000;
        err_next = 1'b0;
        unique case (paddr)
            AMH_SEL_OFS:   rd_next[7:0] = select_reg;
            AMH_CTL_OFS:   rd_next[7:0] = control_reg;
            AMH_STAT_OFS: begin
                rd_next[2:0] = flags;
                rd_next[AMH_STAT_CMP1_BIT] = cmp1_reg;
                rd_next[AMH_STAT_CMP2_BIT] = cmp2_reg;
                rd_next[AMH_STAT_BUSY_BIT] = state_reg == AMH_RAMPING;
            end
            AMH_MASK_OFS:  rd_next[2:0] = mask_reg;
            AMH_COUNT_OFS: rd_next[COUNT_W-1:0] = count_reg;
            default:       err_next = 1'b1;
        endcase
    end

    // one wait state buys registered read data and response
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc && err_next;
            if (acc && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end
endmodule // amh_mux_hold_ctrl
